// ---- rtl/trip_arc_pkg.sv ----
// Contract
// RULE1: zero attempt count means no auto reset
// RULE2: nonzero count auto resets up to count
// RULE3: wait programmed delay, 0.0 to 25.0 s
// RULE4: overload trips wait at least ten seconds
// RULE5: same trip increments counter, different clears
// RULE6: counter at limit blocks further auto reset
// RULE7: five trip-free minutes clear the counter
// RULE8: never auto reset protected trip classes
// RULE9: manual reset clears the counter
// RULE10: hold off clears healthy on every trip
// RULE11: hold on keeps healthy if reset follows
// RULE12: action field 0-7, stop/brake/phase bits
// RULE13: bit 0 clear trips minor faults at once
// RULE14: bit 0 set stops first, regen trips
// RULE15: full brake accumulator trips or disables braking
// RULE16: bit 2 masks phase loss on small drive
// RULE17: attempt count accepts 0 to 5
// RULE18: keep last trip code for comparison
// RULE19: timers run from a fixed background tick; the tick counter here restarts on each trip entry
package trip_arc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_ATTEMPTS = 8'h00;
	localparam logic [7:0] OFS_WAIT     = 8'h04;
	localparam logic [7:0] OFS_KEEP     = 8'h08;
	localparam logic [7:0] OFS_ACTION   = 8'h0C;
	localparam logic [7:0] OFS_STATUS   = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

	localparam logic [2:0]  RST_ATTEMPTS = 3'h0;
	localparam logic [15:0] RST_WAIT     = 16'h0000;
	localparam logic        RST_KEEP     = 1'b0;
	localparam logic [2:0]  RST_ACTION   = 3'h0;
	localparam logic [3:0]  RST_MASK     = 4'h0;

	localparam logic [2:0]  ATTEMPTS_MAX = 3'h5;
	localparam logic [15:0] WAIT_MAX     = 16'h00FA;

	localparam int ACT_STOP_BIT  = 0;
	localparam int ACT_BRAKE_BIT = 1;
	localparam int ACT_PHASE_BIT = 2;

	// irq status bits
	localparam int IRQ_TRIP    = 0;
	localparam int IRQ_AUTO    = 1;
	localparam int IRQ_REFUSED = 2;
	localparam int IRQ_BRAKE   = 3;

	// brake accumulator in 0.1 % steps
	localparam logic [9:0] ACC_FULL    = 10'h3E8;
	localparam logic [9:0] ACC_RELEASE = 10'h3B6;

	// internal trip codes
	localparam logic [7:0] CODE_BRAKE_OVL = 8'h13;
	localparam logic [7:0] CODE_PHASE     = 8'h20;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ      = 200;
	localparam int TICK_MS      = 100;
	localparam int TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
	localparam int FIVE_MIN_S   = 300;
	localparam int OVL_MIN_S    = 10;
	localparam logic [11:0] FIVE_MIN_TICKS = 12'(FIVE_MIN_S * 1000 / TICK_MS);
	localparam logic [15:0] OVL_MIN_TICKS  = 16'(OVL_MIN_S * 1000 / TICK_MS);

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_STOP    = 4'h2,
		ST_TRIPPED = 4'h4,
		ST_WAIT    = 4'h8
	} arc_state_type;

endpackage

// ---- rtl/trip_auto_reset_control.sv ----
`timescale 1ns/1ps
module trip_auto_reset_control #(
	parameter int TICK_CYCLES = trip_arc_pkg::TICK_CYCLES
) (
	input  wire logic        clk,             // system clock
	input  wire logic        rst_n,           // sync reset
	input  wire logic [7:0]  addr,            // register byte address
	input  wire logic [31:0] wr_data,         // write data
	input  wire logic        wr_en,           // write strobe
	input  wire logic        rd_en,           // read strobe
	output logic      [31:0] rd_data_ff,      // read data, next cycle
	input  wire logic        fault_req,       // trip request pulse
	input  wire logic [7:0]  fault_code,      // trip code
	input  wire logic        fault_no_auto,   // protected class
	input  wire logic        fault_overload,  // overload class
	input  wire logic        fault_minor,     // non-important class
	input  wire logic        manual_reset,    // manual reset pulse
	input  wire logic        regen_mode,      // regen operation
	input  wire logic        motor_stopped,   // motor at standstill
	input  wire logic        small_drive,     // smallest LV size
	input  wire logic        phase_loss_det,  // supply phase lost
	input  wire logic [9:0]  brake_energy_accumulator, // 0.1 % units
	output logic             trip_active_ff,  // drive tripped
	output logic             auto_reset_ff,   // auto reset pulse
	output logic             drive_ok_flag_ff,// healthy
	output logic             stop_request_ff, // stop before trip
	output logic             brake_off_ff,    // braking switch disabled
	output logic             irq_ff           // interrupt level
);

	localparam int TW = $clog2(TICK_CYCLES);

	trip_arc_pkg::arc_state_type state_ff;
	logic [2:0]  auto_reset_attempt_count_ff;
	logic [15:0] auto_reset_wait_time_ff;
	logic        keep_healthy_until_final_attempt_ff;
	logic [2:0]  trip_detection_action_ff;
	logic [3:0]  irq_stat_ff;
	logic [3:0]  irq_mask_ff;
	logic [2:0]  cnt_ff;
	logic [7:0]  last_code_ff;
	logic        had_trip_ff;
	logic [7:0]  cap_code_ff;
	logic        cap_ovl_ff;
	logic        cap_noauto_ff;
	logic [15:0] delay_ff;
	logic [TW-1:0] tick_cnt_ff;
	logic [11:0] free_cnt_ff;

	// ------------------------------------------------------------
	// trip detection
	// ------------------------------------------------------------
	logic       idle;
	logic       brake_full;
	logic       phase_trip;
	logic       brake_trip;
	logic       trip_any;
	logic       go_stop;
	logic       enter;
	logic [7:0] new_code;
	logic       new_ovl;
	logic       new_noauto;
	logic       same;
	logic [2:0] base;
	logic       allowed;
	logic       tick;
	logic       fire;
	logic [15:0] dly;
	logic [3:0] irq_set;

	assign idle       = state_ff == trip_arc_pkg::ST_IDLE;
	assign brake_full = brake_energy_accumulator >= trip_arc_pkg::ACC_FULL;
	// RULE15 brake trip option
	assign brake_trip = brake_full && !trip_detection_action_ff[trip_arc_pkg::ACT_BRAKE_BIT];
	// RULE16 phase loss mask
	assign phase_trip = phase_loss_det
		&& !(trip_detection_action_ff[trip_arc_pkg::ACT_PHASE_BIT] && small_drive);
	assign trip_any   = fault_req || brake_trip || phase_trip;

	always_comb begin
		new_code   = cap_code_ff;
		new_ovl    = cap_ovl_ff;
		new_noauto = cap_noauto_ff;
		if (idle) begin
			if (fault_req) begin
				new_code   = fault_code;
				new_ovl    = fault_overload;
				new_noauto = fault_no_auto;
			end else if (brake_trip) begin
				new_code   = trip_arc_pkg::CODE_BRAKE_OVL;
				new_ovl    = 1'b1;
				new_noauto = 1'b0;
			end else begin
				new_code   = trip_arc_pkg::CODE_PHASE;
				new_ovl    = 1'b0;
				new_noauto = 1'b0;
			end
		end
	end

	// RULE13 RULE14 stop or trip
	assign go_stop = fault_req && fault_minor && !regen_mode
		&& trip_detection_action_ff[trip_arc_pkg::ACT_STOP_BIT];
	assign enter = !manual_reset && ((idle && trip_any && !go_stop)
		|| (state_ff == trip_arc_pkg::ST_STOP && motor_stopped));

	// RULE5 RULE18 compare with last
	assign same = had_trip_ff && new_code == last_code_ff;
	assign base = same ? cnt_ff : 3'h0;
	// RULE1 RULE2 RULE6 RULE8 permission
	assign allowed = auto_reset_attempt_count_ff != 3'h0 && !new_noauto
		&& base < auto_reset_attempt_count_ff;
	// RULE3 RULE4 delay with overload floor
	assign dly = (new_ovl && auto_reset_wait_time_ff < trip_arc_pkg::OVL_MIN_TICKS)
		? trip_arc_pkg::OVL_MIN_TICKS : auto_reset_wait_time_ff;

	// RULE19 background tick
	assign tick = tick_cnt_ff == TW'(TICK_CYCLES - 1);
	assign fire = !manual_reset && state_ff == trip_arc_pkg::ST_WAIT && delay_ff == 16'h0000;

	always_ff @(posedge clk) begin
		if (!rst_n || enter || tick)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick_cnt_ff + TW'(1);
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= trip_arc_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				trip_arc_pkg::ST_IDLE: begin
					if (manual_reset)
						state_ff <= trip_arc_pkg::ST_IDLE;
					else if (enter)
						state_ff <= allowed ? trip_arc_pkg::ST_WAIT : trip_arc_pkg::ST_TRIPPED;
					else if (trip_any && go_stop)
						state_ff <= trip_arc_pkg::ST_STOP;
				end
				trip_arc_pkg::ST_STOP: begin
					if (manual_reset)
						state_ff <= trip_arc_pkg::ST_IDLE;
					else if (enter)
						state_ff <= allowed ? trip_arc_pkg::ST_WAIT : trip_arc_pkg::ST_TRIPPED;
				end
				trip_arc_pkg::ST_WAIT: begin
					if (manual_reset || fire)
						state_ff <= trip_arc_pkg::ST_IDLE;
				end
				trip_arc_pkg::ST_TRIPPED: begin
					if (manual_reset)
						state_ff <= trip_arc_pkg::ST_IDLE;
				end
				default: state_ff <= trip_arc_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_code_ff   <= 8'h00;
			cap_ovl_ff    <= 1'b0;
			cap_noauto_ff <= 1'b0;
		end else if (idle && trip_any) begin
			cap_code_ff   <= new_code;
			cap_ovl_ff    <= new_ovl;
			cap_noauto_ff <= new_noauto;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			delay_ff <= 16'h0000;
		else if (enter)
			delay_ff <= dly;
		else if (tick && delay_ff != 16'h0000)
			delay_ff <= delay_ff - 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			last_code_ff <= 8'h00;
			had_trip_ff  <= 1'b0;
		end else if (enter) begin
			last_code_ff <= new_code;
			had_trip_ff  <= 1'b1;
		end
	end

	// RULE7 trip-free timer
	always_ff @(posedge clk) begin
		if (!rst_n || enter)
			free_cnt_ff <= 12'h000;
		else if (tick && free_cnt_ff != trip_arc_pkg::FIVE_MIN_TICKS)
			free_cnt_ff <= free_cnt_ff + 12'h001;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			cnt_ff <= 3'h0;
		// RULE9 manual clear
		else if (manual_reset)
			cnt_ff <= 3'h0;
		// RULE5 keep or clear count
		else if (enter)
			cnt_ff <= base;
		// RULE2 count the attempt
		else if (fire)
			cnt_ff <= cnt_ff + 3'h1;
		// RULE7 idle timeout clear
		else if (free_cnt_ff == trip_arc_pkg::FIVE_MIN_TICKS)
			cnt_ff <= 3'h0;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			trip_active_ff  <= 1'b0;
			auto_reset_ff   <= 1'b0;
			stop_request_ff <= 1'b0;
		end else begin
			auto_reset_ff   <= fire;
			stop_request_ff <= !manual_reset && !enter
				&& (state_ff == trip_arc_pkg::ST_STOP || (idle && trip_any && go_stop));
			if (manual_reset || fire)
				trip_active_ff <= 1'b0;
			else if (enter)
				trip_active_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			drive_ok_flag_ff <= 1'b1;
		else if (manual_reset || fire)
			drive_ok_flag_ff <= 1'b1;
		// RULE10 RULE11 healthy hold
		else if (enter && !(keep_healthy_until_final_attempt_ff && allowed))
			drive_ok_flag_ff <= 1'b0;
	end

	// RULE15 braking switch hysteresis
	always_ff @(posedge clk) begin
		if (!rst_n)
			brake_off_ff <= 1'b0;
		else if (brake_full && trip_detection_action_ff[trip_arc_pkg::ACT_BRAKE_BIT])
			brake_off_ff <= 1'b1;
		else if (brake_energy_accumulator < trip_arc_pkg::ACC_RELEASE)
			brake_off_ff <= 1'b0;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = a == ofs;
	endfunction

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			auto_reset_attempt_count_ff         <= trip_arc_pkg::RST_ATTEMPTS;
			auto_reset_wait_time_ff             <= trip_arc_pkg::RST_WAIT;
			keep_healthy_until_final_attempt_ff <= trip_arc_pkg::RST_KEEP;
			trip_detection_action_ff            <= trip_arc_pkg::RST_ACTION;
			irq_mask_ff                         <= trip_arc_pkg::RST_MASK;
		end else if (wr_en) begin
			// RULE17 clamp attempts
			if (hit(addr, trip_arc_pkg::OFS_ATTEMPTS))
				auto_reset_attempt_count_ff <= (wr_data[2:0] > trip_arc_pkg::ATTEMPTS_MAX)
					? trip_arc_pkg::ATTEMPTS_MAX : wr_data[2:0];
			// RULE3 clamp delay
			if (hit(addr, trip_arc_pkg::OFS_WAIT))
				auto_reset_wait_time_ff <= (wr_data[15:0] > trip_arc_pkg::WAIT_MAX)
					? trip_arc_pkg::WAIT_MAX : wr_data[15:0];
			if (hit(addr, trip_arc_pkg::OFS_KEEP))
				keep_healthy_until_final_attempt_ff <= wr_data[0];
			// RULE12 action field
			if (hit(addr, trip_arc_pkg::OFS_ACTION))
				trip_detection_action_ff <= wr_data[2:0];
			if (hit(addr, trip_arc_pkg::OFS_IRQ_MASK))
				irq_mask_ff <= wr_data[3:0];
		end
	end

	assign irq_set = {brake_full && trip_detection_action_ff[trip_arc_pkg::ACT_BRAKE_BIT]
		&& !brake_off_ff, enter && !allowed, fire, enter};

	// set wins over write-one-clear
	always_ff @(posedge clk) begin
		if (!rst_n)
			irq_stat_ff <= 4'h0;
		else if (wr_en && hit(addr, trip_arc_pkg::OFS_IRQ_STAT))
			irq_stat_ff <= (irq_stat_ff & ~wr_data[3:0]) | irq_set;
		else
			irq_stat_ff <= irq_stat_ff | irq_set;
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_stat_ff & irq_mask_ff);
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !rd_en) begin
			rd_data_ff <= 32'h0000_0000;
		end else begin
			case (addr)
				trip_arc_pkg::OFS_ATTEMPTS: rd_data_ff <= {29'h0, auto_reset_attempt_count_ff};
				trip_arc_pkg::OFS_WAIT:     rd_data_ff <= {16'h0, auto_reset_wait_time_ff};
				trip_arc_pkg::OFS_KEEP:
					rd_data_ff <= {31'h0, keep_healthy_until_final_attempt_ff};
				trip_arc_pkg::OFS_ACTION:   rd_data_ff <= {29'h0, trip_detection_action_ff};
				trip_arc_pkg::OFS_STATUS:
					rd_data_ff <= {16'h0, last_code_ff, 1'b0, stop_request_ff, brake_off_ff,
						drive_ok_flag_ff, trip_active_ff, cnt_ff};
				trip_arc_pkg::OFS_IRQ_STAT: rd_data_ff <= {28'h0, irq_stat_ff};
				trip_arc_pkg::OFS_IRQ_MASK: rd_data_ff <= {28'h0, irq_mask_ff};
				default:                    rd_data_ff <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	zero_count_a: assert property (auto_reset_attempt_count_ff == 3'h0 |-> !fire) // RULE1
		else $error("auto reset with zero attempt count");
	enter_wait_a: assert property (enter && allowed |=> state_ff == trip_arc_pkg::ST_WAIT) // RULE2
		else $error("allowed trip did not wait");
	delay_hold_a: assert property (enter && dly != 16'h0000 |=> !fire) // RULE3
		else $error("auto reset before delay");
	ovl_floor_a: assert property (enter && new_ovl // RULE4
		|=> delay_ff >= trip_arc_pkg::OVL_MIN_TICKS)
		else $error("overload delay below floor");
	diff_clear_a: assert property (enter && !same && !manual_reset |=> cnt_ff == 3'h0) // RULE5
		else $error("count kept on different trip");
	limit_block_a: assert property (state_ff == trip_arc_pkg::ST_WAIT // RULE6
		|-> cnt_ff < auto_reset_attempt_count_ff || !$stable(auto_reset_attempt_count_ff))
		else $error("waiting with count at limit");
	idle_clear_a: assert property (free_cnt_ff == trip_arc_pkg::FIVE_MIN_TICKS // RULE7
		&& !manual_reset && !enter && !fire |=> cnt_ff == 3'h0)
		else $error("count kept after trip-free interval");
	noauto_block_a: assert property (enter && new_noauto // RULE8
		|=> state_ff != trip_arc_pkg::ST_WAIT)
		else $error("protected trip auto reset");
	manual_clear_a: assert property (manual_reset |=> cnt_ff == 3'h0) // RULE9
		else $error("manual reset kept count");
	healthy_drop_a: assert property (enter && !keep_healthy_until_final_attempt_ff
		|=> !drive_ok_flag_ff) // RULE10
		else $error("healthy kept with hold off");
	healthy_keep_a: assert property (enter && keep_healthy_until_final_attempt_ff && allowed
		&& drive_ok_flag_ff |=> drive_ok_flag_ff) // RULE11
		else $error("healthy dropped with hold on");
	fire_pulse_a: assert property (fire |=> auto_reset_ff ##1 !auto_reset_ff) // RULE2
		else $error("auto reset pulse wrong");
	minor_trip_a: assert property (idle && fault_req && fault_minor && !manual_reset // RULE13
		&& !trip_detection_action_ff[trip_arc_pkg::ACT_STOP_BIT] |=> trip_active_ff)
		else $error("minor trip did not trip at once");
	brake_off_a: assert property (brake_full && trip_detection_action_ff[1] // RULE15
		|=> brake_off_ff)
		else $error("braking switch not disabled");

	auto_cycle_c: cover property (enter && allowed ##[1:300] fire);
	stop_first_c: cover property (state_ff == trip_arc_pkg::ST_STOP ##[1:50] enter);
	refused_c:    cover property (enter && same && !allowed);
	brake_off_c:  cover property ($rose(brake_off_ff));

endmodule // trip_auto_reset_control

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb;
	localparam int T   = 10;
	localparam int LIM = 40000;
	logic        clk = 1'b0;
	logic        rst_n;
	logic [7:0]  addr;
	logic [31:0] wr_data;
	logic        wr_en;
	logic        rd_en;
	logic        fault_req;
	logic [7:0]  fault_code;
	logic        fault_no_auto;
	logic        fault_overload;
	logic        fault_minor;
	logic        manual_reset;
	logic        regen_mode;
	logic        motor_stopped;
	logic        small_drive;
	logic        phase_loss_det;
	logic [9:0]  brake_energy_accumulator;
	logic [31:0] rd_data_ff;
	logic        trip_active_ff;
	logic        auto_reset_ff;
	logic        drive_ok_flag_ff;
	logic        stop_request_ff;
	logic        brake_off_ff;
	logic        irq_ff;
	int          err_total = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          n;
	int          w;
	logic [31:0] seed = 32'h0000005F;
	logic [31:0] v;
	logic [7:0]  c;

	trip_auto_reset_control #(.TICK_CYCLES(T)) i_trip_auto_reset_control (
		.clk(clk),
		.rst_n(rst_n),
		.addr(addr),
		.wr_data(wr_data),
		.wr_en(wr_en),
		.rd_en(rd_en),
		.rd_data_ff(rd_data_ff),
		.fault_req(fault_req),
		.fault_code(fault_code),
		.fault_no_auto(fault_no_auto),
		.fault_overload(fault_overload),
		.fault_minor(fault_minor),
		.manual_reset(manual_reset),
		.regen_mode(regen_mode),
		.motor_stopped(motor_stopped),
		.small_drive(small_drive),
		.phase_loss_det(phase_loss_det),
		.brake_energy_accumulator(brake_energy_accumulator),
		.trip_active_ff(trip_active_ff),
		.auto_reset_ff(auto_reset_ff),
		.drive_ok_flag_ff(drive_ok_flag_ff),
		.stop_request_ff(stop_request_ff),
		.brake_off_ff(brake_off_ff),
		.irq_ff(irq_ff)
	);

	always #2.5 clk = ~clk;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == LIM) begin
			err_total++;
			report_and_stop;
		end
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// cycles from trip entry to the auto reset pulse
	function automatic int delay_cycles(input int ticks, input logic ovl);
		int t;
		t = ticks;
		if (ovl && ticks < int'(trip_arc_pkg::OVL_MIN_TICKS))
			t = int'(trip_arc_pkg::OVL_MIN_TICKS);
		return t * T + 1;
	endfunction

	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s exp %0h got %0h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		n_tests++;
		if (g < lo || g > hi) begin
			err_total++;
			$display("mismatch %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		d = rd_data_ff;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] d;
		rd(a, d);
		chk_val(nm, e, d);
	endtask

	// class bits: 2 minor, 1 overload, 0 protected
	task automatic trip(input logic [7:0] cd, input logic [2:0] cls);
		@(posedge clk);
		fault_req <= 1'b1;
		fault_code <= cd;
		fault_no_auto <= cls[0];
		fault_overload <= cls[1];
		fault_minor <= cls[2];
		@(posedge clk);
		fault_req <= 1'b0;
		#1;
	endtask

	task automatic mreset;
		@(posedge clk);
		manual_reset <= 1'b1;
		@(posedge clk);
		manual_reset <= 1'b0;
		#1;
	endtask

	task automatic cw(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// cycles until the auto reset pulse, lim if none
	task automatic wait_auto(input int lim, output int k);
		k = 0;
		while (auto_reset_ff !== 1'b1 && k < lim) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		{addr, wr_data, wr_en, rd_en, fault_req, fault_code} = '0;
		{fault_no_auto, fault_overload, fault_minor, manual_reset} = '0;
		{regen_mode, motor_stopped, small_drive, phase_loss_det} = '0;
		brake_energy_accumulator = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rc(trip_arc_pkg::OFS_ATTEMPTS, 32'h0, "attempts");
		rc(trip_arc_pkg::OFS_WAIT, 32'h0, "wait");
		rc(trip_arc_pkg::OFS_KEEP, 32'h0, "keep");
		rc(trip_arc_pkg::OFS_ACTION, 32'h0, "action");
		rc(trip_arc_pkg::OFS_IRQ_MASK, 32'h0, "mask");
		rc(8'hFC, 32'h0, "unmapped");
		wr(trip_arc_pkg::OFS_ACTION, 32'h7);
		rc(trip_arc_pkg::OFS_ACTION, 32'h7, "action");
		wr(trip_arc_pkg::OFS_ACTION, 32'h0);
		wr(trip_arc_pkg::OFS_WAIT, 32'hFFFF);
		rc(trip_arc_pkg::OFS_WAIT, 32'(trip_arc_pkg::WAIT_MAX), "wait");
		wr(trip_arc_pkg::OFS_WAIT, 32'h1);
		v = xs();
		trip(v[7:0], 3'b000);
		chk_val("healthy", 0, drive_ok_flag_ff);
		wait_auto(300, n);
		chk_rng("auto", 300, 300, n);
		mreset;
		// repeated identical trips, manual clear, then a different code
		wr(trip_arc_pkg::OFS_ATTEMPTS, 32'h2);
		v = xs();
		c = v[7:0];
		w = 1 + int'(v[9:8]);
		wr(trip_arc_pkg::OFS_WAIT, 32'(w));
		for (int i = 1; i <= 2; i++) begin
			trip(c, 3'b000);
			wait_auto(80, n);
			chk_rng("delay", delay_cycles(w, 1'b0), delay_cycles(w, 1'b0), n);
			rd(trip_arc_pkg::OFS_STATUS, v);
			chk_val("count", i, v[2:0]);
			chk_val("code", c, v[15:8]);
		end
		trip(c, 3'b000);
		wait_auto(100, n);
		chk_rng("auto", 100, 100, n);
		rc(trip_arc_pkg::OFS_STATUS, {16'h0, c, 8'h0A}, "status");
		mreset;
		rd(trip_arc_pkg::OFS_STATUS, v);
		chk_val("count", 0, v[2:0]);
		trip(c, 3'b000);
		wait_auto(80, n);
		trip(c ^ 8'h01, 3'b000);
		wait_auto(80, n);
		rd(trip_arc_pkg::OFS_STATUS, v);
		chk_val("count", 1, v[2:0]);
		// protected class, hold healthy, overload floor
		wr(trip_arc_pkg::OFS_ATTEMPTS, 32'h7);
		rc(trip_arc_pkg::OFS_ATTEMPTS, 32'h5, "attempts");
		wr(trip_arc_pkg::OFS_KEEP, 32'h1);
		v = xs();
		trip(v[7:0], 3'b001);
		chk_val("healthy", 0, drive_ok_flag_ff);
		wait_auto(100, n);
		chk_rng("auto", 100, 100, n);
		mreset;
		trip(v[15:8], 3'b000);
		chk_val("healthy", 1, drive_ok_flag_ff);
		wait_auto(80, n);
		chk_val("healthy", 1, drive_ok_flag_ff);
		wr(trip_arc_pkg::OFS_WAIT, 32'h1);
		trip(v[23:16], 3'b010);
		w = delay_cycles(1, 1'b1);
		wait_auto(w + 100, n);
		chk_rng("ovl delay", w, w, n);
		// minor trips
		wr(trip_arc_pkg::OFS_KEEP, 32'h0);
		wr(trip_arc_pkg::OFS_ATTEMPTS, 32'h0);
		trip(8'h31, 3'b100);
		chk_val("trip", 1, {stop_request_ff, trip_active_ff});
		mreset;
		wr(trip_arc_pkg::OFS_ACTION, 32'h1);
		trip(8'h31, 3'b100);
		cw(5);
		chk_val("stop", 2, {stop_request_ff, trip_active_ff});
		motor_stopped <= 1'b1;
		cw(3);
		chk_val("stop", 1, {stop_request_ff, trip_active_ff});
		mreset;
		regen_mode <= 1'b1;
		trip(8'h31, 3'b100);
		chk_val("regen", 1, {stop_request_ff, trip_active_ff});
		mreset;
		regen_mode <= 1'b0;
		// braking accumulator
		wr(trip_arc_pkg::OFS_ACTION, 32'h0);
		brake_energy_accumulator <= trip_arc_pkg::ACC_FULL - 10'h001;
		cw(4);
		chk_val("brake", 0, trip_active_ff);
		brake_energy_accumulator <= trip_arc_pkg::ACC_FULL;
		cw(3);
		chk_val("brake", 1, trip_active_ff);
		brake_energy_accumulator <= '0;
		rc(trip_arc_pkg::OFS_STATUS, {16'h0, trip_arc_pkg::CODE_BRAKE_OVL, 8'h08}, "status");
		mreset;
		wr(trip_arc_pkg::OFS_ACTION, 32'h2);
		brake_energy_accumulator <= trip_arc_pkg::ACC_FULL;
		cw(3);
		chk_val("brake", 2, {brake_off_ff, trip_active_ff});
		brake_energy_accumulator <= trip_arc_pkg::ACC_RELEASE;
		cw(3);
		chk_val("brake", 1, brake_off_ff);
		brake_energy_accumulator <= trip_arc_pkg::ACC_RELEASE - 10'h001;
		cw(3);
		chk_val("brake", 0, brake_off_ff);
		// phase loss
		for (int i = 0; i < 3; i++) begin
			wr(trip_arc_pkg::OFS_ACTION, (i == 2) ? 32'h0 : 32'h4);
			small_drive <= (i != 1);
			phase_loss_det <= 1'b1;
			cw(4);
			chk_val("phase", (i != 0), trip_active_ff);
			phase_loss_det <= 1'b0;
			mreset;
		end
		// interrupts
		rc(trip_arc_pkg::OFS_IRQ_STAT, 32'hF, "irq stat");
		chk_val("irq", 0, irq_ff);
		wr(trip_arc_pkg::OFS_IRQ_MASK, 32'h8);
		cw(2);
		chk_val("irq", 1, irq_ff);
		wr(trip_arc_pkg::OFS_IRQ_STAT, 32'h8);
		cw(2);
		chk_val("irq", 0, irq_ff);
		rc(trip_arc_pkg::OFS_IRQ_STAT, 32'h7, "irq stat");
		// trip-free interval
		wr(trip_arc_pkg::OFS_ATTEMPTS, 32'h3);
		wr(trip_arc_pkg::OFS_WAIT, 32'h0);
		trip(8'h44, 3'b000);
		wait_auto(20, n);
		w = int'(trip_arc_pkg::FIVE_MIN_TICKS) * T;
		cw(w - 60);
		rd(trip_arc_pkg::OFS_STATUS, v);
		chk_val("count", 1, v[2:0]);
		cw(80);
		rd(trip_arc_pkg::OFS_STATUS, v);
		chk_val("count", 0, v[2:0]);
		report_and_stop;
	end
endmodule // tb
